//--- bench/rcs_ctrl_tb.sv
// self-checking bench of the remote calibration and serial status block
// assumes rcs_ctrl with shortened warm-up, report and bit counts
`timescale 1ns/10ps
module rcs_ctrl_tb;
    localparam int BIT_CYC = 16;
    localparam int RPT = 6000;
    logic ref_clk, rst, zero_req_in, span_req_in, cal_contact_closed, cal_done_in;
    logic cal_zero_run, cal_span_run, valve_sample, valve_zero, valve_span;
    logic [15:0] conc_bcd_in, scale_bcd_in, conc_hold_out, sts;
    logic [1:0] auto_range_in;
    logic [2:0] alarm_disabled_in, alarm_tripped_in;
    logic [3:0] range_relay;
    logic key_press_in, warmup_active, reprogram_en, status_en, serial_rx, serial_tx;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    string e;
    string nl = "\015\012";
    string cmds[8] = '{"rp", "st", "st", "rm1", "rm3", "rm2", "ra", "rm4"};
    logic [15:0] exps[8] = '{16'h40c4, 16'h4044, 16'h40c4, 16'h10c4,
                             16'h40c4, 16'h20c4, 16'h40c4, 16'h80c4};

    // port state word for whole-state compares
    assign sts = {range_relay, 3'h0, warmup_active, status_en, reprogram_en,
                  cal_contact_closed, cal_zero_run, cal_span_run,
                  valve_sample, valve_zero, valve_span};

    rcs_ctrl #(.WARMUP_CYC(40'd200), .REPORT_CYC(32'(RPT)), .BIT_CYC(16'(BIT_CYC))) i_rcs_ctrl (
        .ref_clk, .rst, .zero_req_in, .span_req_in, .cal_contact_closed, .cal_done_in,
        .cal_zero_run, .cal_span_run, .valve_sample, .valve_zero, .valve_span,
        .conc_bcd_in, .scale_bcd_in, .auto_range_in, .alarm_disabled_in,
        .alarm_tripped_in, .conc_hold_out, .range_relay, .key_press_in,
        .warmup_active, .reprogram_en, .status_en, .serial_rx, .serial_tx);

    rcs_host_model #(.BIT_CYC(BIT_CYC)) i_rcs_host_model (
        .ref_clk, .cal_contact_closed, .zero_req_in, .span_req_in, .serial_tx, .serial_rx);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk_val({8'h00, got}, {8'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic done_pulse();
        cyc(1);
        cal_done_in = 1'b1;
        cyc(1);
        cal_done_in = 1'b0;
    endtask

    task automatic wait_contact(input logic v);
        for (int n = 0; n < 40 && cal_contact_closed !== v; n++) cyc(1);
        chk_val({15'h0, cal_contact_closed}, {15'h0, v});
    endtask

    task automatic do_reset();
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        cyc(1);
    endtask

    initial begin
        rst = 1'b1;
        cal_done_in = 1'b0;
        conc_bcd_in = 16'h1234;
        scale_bcd_in = 16'h0100;
        auto_range_in = 2'h0;
        alarm_disabled_in = 3'h1;
        alarm_tripped_in = 3'h4;
        key_press_in = 1'b0;
        do_reset();
        chk_val(sts, 16'h1184);
        i_rcs_host_model.remote_cal(1'b0, 1'b0);
        chk_val(sts, 16'h1184);
        cyc(180);
        chk_val(sts, 16'h1084);
        i_rcs_host_model.remote_cal(1'b0, 1'b0);
        cyc(1);
        chk_val(sts, 16'h80b2);
        conc_bcd_in = 16'h9999;
        i_rcs_host_model.remote_cal(1'b1, 1'b1);
        cyc(10);
        chk_val(conc_hold_out, 16'h1234);
        i_rcs_host_model.drop_req();
        cyc(3);
        done_pulse();
        cyc(10);
        chk_val(sts, 16'h1084);
        chk_val(conc_hold_out, 16'h9999);
        i_rcs_host_model.remote_cal(1'b1, 1'b1);
        chk_val(sts, 16'h80a9);
        done_pulse();
        wait_contact(1'b0);
        wait_contact(1'b1);
        chk_val(sts, 16'h80a9);
        i_rcs_host_model.drop_req();
        cyc(3);
        done_pulse();
        cyc(10);
        chk_val(sts, 16'h1084);
        i_rcs_host_model.send_word("az");
        wait_contact(1'b1);
        chk_val(sts, 16'h80b2);
        done_pulse();
        i_rcs_host_model.send_word("as");
        wait_contact(1'b1);
        chk_val(sts, 16'h80a9);
        done_pulse();
        conc_bcd_in = 16'h0456;
        auto_range_in = 2'h2;
        for (int i = 0; i < 8; i++) begin
            i_rcs_host_model.send_word(cmds[i]);
            cyc(3);
            chk_val(sts, exps[i]);
        end
        i_rcs_host_model.send_word("st");
        cyc(5000);
        i_rcs_host_model.rx_q.delete();
        cyc(RPT + 500);
        chk_val(16'(i_rcs_host_model.rx_q.size()), 16'h0);
        i_rcs_host_model.send_word("st");
        cyc(RPT + 4600);
        e = {"0456", nl, "CAL", nl, "0100", nl, "D--", nl, "--T", nl};
        for (int i = 0; i < 27; i++) begin
            chk_byte(i_rcs_host_model.rx_q[i], 8'(e[i]));
        end
        chk_val(16'(i_rcs_host_model.frame_err), 16'h0);
        i_rcs_host_model.send_word("ra");
        i_rcs_host_model.rx_q.delete();
        cyc(RPT);
        e = {"0456", nl, "03", nl, "0100", nl, "D--", nl, "--T", nl};
        for (int i = 0; i < 26; i++) begin
            chk_byte(i_rcs_host_model.rx_q[i], 8'(e[i]));
        end
        auto_range_in = 2'h0;
        do_reset();
        chk_val(sts, 16'h1184);
        cyc(50);
        key_press_in = 1'b1;
        cyc(4);
        key_press_in = 1'b0;
        chk_val(sts, 16'h1084);
        test_done();
    end
endmodule

//--- bench/rcs_host_model.sv
// host model: remote calibration controller and serial terminal
// assumes the block's ref_clk; drives its lines at the falling edge
`timescale 1ns/10ps
module rcs_host_model #(
    parameter int BIT_CYC = 16
) (
    // clock
    input wire logic ref_clk,
    // remote calibration
    input wire logic cal_contact_closed,
    output logic zero_req_in,
    output logic span_req_in,
    // serial line
    input wire logic serial_tx,
    output logic serial_rx
);
    logic [7:0] rx_q[$];
    int frame_err = 0;

    initial begin
        zero_req_in = 1'b0;
        span_req_in = 1'b0;
        serial_rx = 1'b1;
    end

    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            @(negedge ref_clk);
            serial_rx = i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i - 1];
            repeat (BIT_CYC - 1) @(negedge ref_clk);
        end
    endtask

    task automatic send_word(input string w);
        for (int i = 0; i < w.len(); i++) begin
            send_byte(w[i]);
        end
        send_byte(8'h0d);
    endtask

    task automatic drop_req();
        zero_req_in = 1'b0;
        span_req_in = 1'b0;
    endtask

    task automatic remote_cal(input logic span, input logic hold);
        @(negedge ref_clk);
        zero_req_in = !span;
        span_req_in = span;
        for (int n = 0; n < 20 && !cal_contact_closed; n++) @(negedge ref_clk);
        if (!hold) begin
            drop_req();
        end
    endtask

    initial begin
        logic [7:0] b;
        forever begin
            @(negedge serial_tx);
            repeat (BIT_CYC / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge ref_clk);
                b[i] = serial_tx;
            end
            repeat (BIT_CYC) @(posedge ref_clk);
            if (serial_tx !== 1'b1) frame_err++;
            rx_q.push_back(b);
        end
    end
endmodule

//--- logic/rcs_ctrl.sv
// remote calibration handshake, serial status reports and commands, warm-up lockout
// assumes a 40 MHz ref_clk and rst held at power-up; cal_done_in from the cal core
//
// Operation
// - contact open when idle; remote zero and span polled and accepted
// - requests during calibration are dropped, never queued
// - request still high at completion starts the same calibration again
// - held concentration frozen while the contact is closed
// - contact closed for the whole zero or span calibration
// - zero input selects zero mode, span input selects span mode
// - valve lines follow the current calibration mode
// - range relays ascend by range; relay four is the cal range
// - periodic report: concentration, range, scale, disabled, tripped alarms
// - range sent as 01, 02, 03 or CAL
// - every report item ends in carriage return and line feed
// - autospan and autozero commands start that calibration at once
// - status toggle command flips report suppression
// - reprogram command enables reprogramming
// - link runs 2400 baud, 8 data bits, no parity, 1 stop
// - thirty minute warm-up after power-up, ended early by a key press
// - during warm-up remote calibration ignored and no reports sent
// - every reset restarts the full warm-up
`timescale 1ns/10ps
`include "rcs_defines.svh"
module rcs_ctrl #(
    parameter logic [39:0] WARMUP_CYC = 40'(`RCS_WARMUP_S * `RCS_CLK_HZ),
    parameter logic [31:0] REPORT_CYC = 32'(`RCS_REPORT_MS * `RCS_CLK_HZ / 64'd1000),
    parameter logic [15:0] BIT_CYC = 16'(`RCS_CLK_HZ / `RCS_BAUD)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // remote calibration inputs and contact
    input wire logic zero_req_in,
    input wire logic span_req_in,
    output logic cal_contact_closed,
    // calibration core
    input wire logic cal_done_in,
    output logic cal_zero_run,
    output logic cal_span_run,
    // gas valves
    output logic valve_sample,
    output logic valve_zero,
    output logic valve_span,
    // measurement and display
    input wire logic [15:0] conc_bcd_in,
    input wire logic [15:0] scale_bcd_in,
    input wire logic [1:0] auto_range_in,
    input wire logic [2:0] alarm_disabled_in,
    input wire logic [2:0] alarm_tripped_in,
    output logic [15:0] conc_hold_out,
    output logic [3:0] range_relay,
    // front panel
    input wire logic key_press_in,
    output logic warmup_active,
    output logic reprogram_en,
    output logic status_en,
    // serial line
    input wire logic serial_rx,
    output logic serial_tx
);
    localparam rcs_pkg::rcs_main_s MAIN_RST = '{
        state: rcs_pkg::RCS_IDLE,
        warm: `RCS_RST_WARM,
        stat_en: `RCS_RST_STAT_EN,
        v_sample: 1'b1,
        relay: 4'b0001,
        default: '0
    };

    rcs_pkg::rcs_main_s r;
    rcs_pkg::rcs_main_s n;
    rcs_uart_if u ();

    logic is_cr;
    logic two_char_end;
    logic hit_auto_span;
    logic hit_auto_zero;
    logic hit_status_toggle;
    logic hit_reprogram;
    logic hit_auto_range;
    logic hit_manual_range;
    logic [7:0] char_now;

    rcs_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
        .ref_clk(ref_clk),
        .rst(rst),
        .u(u.tx),
        .serial_tx(serial_tx)
    );

    rcs_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
        .ref_clk(ref_clk),
        .rst(rst),
        .serial_rx(serial_rx),
        .u(u.rx)
    );

    // report character at a position
    function automatic logic [7:0] rpt_char(
        input logic [4:0] i,
        input logic [15:0] conc,
        input logic [1:0] rng,
        input logic [15:0] scale,
        input logic [2:0] dis,
        input logic [2:0] trip
    );
        logic cal;
        cal = (rng == `RCS_RANGE_CAL);
        unique case (i)
            5'h00: rpt_char = `RCS_CH_0 + {4'h0, conc[15:12]};
            5'h01: rpt_char = `RCS_CH_0 + {4'h0, conc[11:8]};
            5'h02: rpt_char = `RCS_CH_0 + {4'h0, conc[7:4]};
            5'h03: rpt_char = `RCS_CH_0 + {4'h0, conc[3:0]};
            5'h06: rpt_char = cal ? `RCS_CH_C : `RCS_CH_0;
            5'h07: rpt_char = cal ? `RCS_CH_A : `RCS_CH_1 + {6'h00, rng};
            5'h08: rpt_char = `RCS_CH_L;
            5'h0b: rpt_char = `RCS_CH_0 + {4'h0, scale[15:12]};
            5'h0c: rpt_char = `RCS_CH_0 + {4'h0, scale[11:8]};
            5'h0d: rpt_char = `RCS_CH_0 + {4'h0, scale[7:4]};
            5'h0e: rpt_char = `RCS_CH_0 + {4'h0, scale[3:0]};
            5'h11: rpt_char = dis[0] ? `RCS_CH_D : `RCS_CH_DASH;
            5'h12: rpt_char = dis[1] ? `RCS_CH_D : `RCS_CH_DASH;
            5'h13: rpt_char = dis[2] ? `RCS_CH_D : `RCS_CH_DASH;
            5'h16: rpt_char = trip[0] ? `RCS_CH_T : `RCS_CH_DASH;
            5'h17: rpt_char = trip[1] ? `RCS_CH_T : `RCS_CH_DASH;
            5'h18: rpt_char = trip[2] ? `RCS_CH_T : `RCS_CH_DASH;
            5'h04, 5'h09, 5'h0f, 5'h14, 5'h19: rpt_char = `RCS_CH_CR;
            default: rpt_char = `RCS_CH_LF;
        endcase
    endfunction

    // command decode on enter
    assign is_cr = u.rx_valid && (u.rx_data == `RCS_CH_CR);
    assign two_char_end = is_cr && (r.rx_len == 3'h2);
    assign hit_auto_span = two_char_end && (r.rx_buf[15:0] == `RCS_AUTO_SPAN_CMD);
    assign hit_auto_zero = two_char_end && (r.rx_buf[15:0] == `RCS_AUTO_ZERO_CMD);
    assign hit_status_toggle = two_char_end && (r.rx_buf[15:0] == `RCS_STATUS_TOGGLE_CMD);
    assign hit_reprogram = two_char_end && (r.rx_buf[15:0] == `RCS_REPROGRAM_CMD);
    assign hit_auto_range = two_char_end && (r.rx_buf[15:0] == `RCS_AUTO_RANGE_CMD);
    assign hit_manual_range = is_cr && (r.rx_len == 3'h3)
        && (r.rx_buf[23:8] == `RCS_MANUAL_RANGE_CMD)
        && (r.rx_buf[7:0] >= `RCS_CH_1) && (r.rx_buf[7:0] <= `RCS_CH_FOUR);
    assign char_now = rpt_char(r.tx_idx, r.hold, r.range_use, scale_bcd_in,
        alarm_disabled_in, alarm_tripped_in);

    always_comb begin
        n = r;
        n.zero_s1 = zero_req_in;
        n.zero_s2 = r.zero_s1;
        n.span_s1 = span_req_in;
        n.span_s2 = r.span_s1;
        n.key_s1 = key_press_in;
        n.key_s2 = r.key_s1;

        // command line buffer
        if (u.rx_valid) begin
            if (u.rx_data == `RCS_CH_CR) begin
                n.rx_len = 3'h0;
            end else if (u.rx_data != `RCS_CH_LF) begin
                n.rx_buf = {r.rx_buf[15:0], u.rx_data};
                n.rx_len = (r.rx_len == 3'h4) ? 3'h4 : r.rx_len + 3'h1;
            end
        end

        if (r.warm) begin
            if (r.key_s2 || (r.warm_cnt == WARMUP_CYC - 40'h1)) begin
                n.warm = 1'b0;
            end else begin
                n.warm_cnt = r.warm_cnt + 40'h1;
            end
        end

        unique case (r.state)
            rcs_pkg::RCS_IDLE: begin
                if (!r.warm) begin
                    if (r.zero_s2 || hit_auto_zero) begin
                        n.state = rcs_pkg::RCS_ZERO;
                    end else if (r.span_s2 || hit_auto_span) begin
                        n.state = rcs_pkg::RCS_SPAN;
                    end
                end
            end
            rcs_pkg::RCS_ZERO, rcs_pkg::RCS_SPAN: begin
                if (cal_done_in) begin
                    n.state = rcs_pkg::RCS_IDLE;
                end
            end
            default: n.state = rcs_pkg::RCS_IDLE;
        endcase

        n.busy = (n.state != rcs_pkg::RCS_IDLE);
        n.v_zero = (n.state == rcs_pkg::RCS_ZERO);
        n.v_span = (n.state == rcs_pkg::RCS_SPAN);
        n.v_sample = (n.state == rcs_pkg::RCS_IDLE);

        if (n.state == rcs_pkg::RCS_IDLE) begin
            n.hold = conc_bcd_in;
        end

        if (hit_auto_range) begin
            n.man = 1'b0;
        end
        if (hit_manual_range) begin
            n.man = 1'b1;
            n.sel = r.rx_buf[1:0] - 2'h1;
        end
        n.range_use = n.busy ? `RCS_RANGE_CAL : (n.man ? n.sel : auto_range_in);
        n.relay = 4'b0001 << n.range_use;

        if (hit_status_toggle) begin
            n.stat_en = !r.stat_en;
        end
        if (hit_reprogram) begin
            n.reprog = 1'b1;
        end

        n.rep_cnt = (r.rep_cnt == REPORT_CYC - 32'h1) ? 32'h0 : r.rep_cnt + 32'h1;
        if ((r.rep_cnt == REPORT_CYC - 32'h1) && r.stat_en && !r.warm && !r.tx_act) begin
            n.tx_act = 1'b1;
            n.tx_idx = 5'h00;
        end

        // report byte handshake
        if (r.tx_valid && u.tx_ready) begin
            n.tx_valid = 1'b0;
            if (r.tx_idx == `RCS_RPT_LAST) begin
                n.tx_act = 1'b0;
            end else if (r.tx_idx == `RCS_RPT_RANGE_MID && r.range_use != `RCS_RANGE_CAL) begin
                n.tx_idx = r.tx_idx + 5'h02;
            end else begin
                n.tx_idx = r.tx_idx + 5'h01;
            end
        end else if (r.tx_act && !r.tx_valid) begin
            n.tx_valid = 1'b1;
            n.tx_data = char_now;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= MAIN_RST;
        end else begin
            r <= n;
        end
    end

    assign u.tx_valid = r.tx_valid;
    assign u.tx_data = r.tx_data;
    assign cal_contact_closed = r.busy;
    assign cal_zero_run = r.v_zero;
    assign cal_span_run = r.v_span;
    assign valve_sample = r.v_sample;
    assign valve_zero = r.v_zero;
    assign valve_span = r.v_span;
    assign conc_hold_out = r.hold;
    assign range_relay = r.relay;
    assign warmup_active = r.warm;
    assign reprogram_en = r.reprog;
    assign status_en = r.stat_en;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_idle_accept;
        (r.state == rcs_pkg::RCS_IDLE && !r.warm && r.zero_s2) |=>
            (r.state == rcs_pkg::RCS_ZERO) && cal_contact_closed && valve_zero;
    endproperty
    a_idle_accept: assert property (p_idle_accept) else $error("zero request not taken");

    property p_busy_drop;
        (r.state != rcs_pkg::RCS_IDLE && !cal_done_in && (r.zero_s2 || r.span_s2)) |=>
            (r.state == $past(r.state));
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("request acted on while busy");

    property p_rerun;
        (cal_done_in && ((r.state == rcs_pkg::RCS_ZERO && r.zero_s2 && r.zero_s1)
            || (r.state == rcs_pkg::RCS_SPAN && r.span_s2 && r.span_s1 && !r.zero_s1))) |=>
            !cal_contact_closed ##1 cal_contact_closed && (r.state == $past(r.state, 2));
    endproperty
    a_rerun: assert property (p_rerun) else $error("held request did not rerun");

    property p_hold;
        (cal_contact_closed && r.state != rcs_pkg::RCS_IDLE && !cal_done_in) |=>
            $stable(conc_hold_out);
    endproperty
    a_hold: assert property (p_hold) else $error("held reading changed in cal");

    property p_contact;
        cal_contact_closed == (cal_zero_run || cal_span_run);
    endproperty
    a_contact: assert property (p_contact) else $error("contact not matching cal");

    property p_valves;
        $onehot({valve_sample, valve_zero, valve_span}) && (valve_sample == !cal_contact_closed);
    endproperty
    a_valves: assert property (p_valves) else $error("valve lines wrong");

    property p_relay;
        $onehot(range_relay) && (!cal_contact_closed || range_relay[3]);
    endproperty
    a_relay: assert property (p_relay) else $error("range relay wrong");

    property p_toggle;
        hit_status_toggle |=> (status_en != $past(status_en));
    endproperty
    a_toggle: assert property (p_toggle) else $error("status toggle failed");

    property p_warm_quiet;
        warmup_active |-> !r.tx_act && !cal_contact_closed;
    endproperty
    a_warm_quiet: assert property (p_warm_quiet) else $error("activity during warm-up");

    property p_key_end;
        (warmup_active && r.key_s2) |=> !warmup_active;
    endproperty
    a_key_end: assert property (p_key_end) else $error("key did not end warm-up");

    property p_term;
        (r.tx_valid && u.tx_ready && r.tx_data == `RCS_CH_CR) |=>
            ##[1:3] (r.tx_valid && r.tx_data == `RCS_CH_LF);
    endproperty
    a_term: assert property (p_term) else $error("CR not followed by LF");

    c_zero_cal: cover property (r.state == rcs_pkg::RCS_ZERO ##1 cal_done_in);
    c_span_cal: cover property (r.state == rcs_pkg::RCS_SPAN ##1 cal_done_in);
    c_report: cover property (r.tx_valid && r.tx_idx == `RCS_RPT_LAST);
    c_warm_end: cover property (warmup_active ##1 !warmup_active);
endmodule

//--- logic/rcs_defines.svh
// constants of the remote calibration and serial status block
// assumes one 40 MHz clock; included by bare name
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// clock and link timing
`define RCS_CLK_HZ 64'd40000000
`define RCS_BAUD 64'd2400
`define RCS_REPORT_MS 64'd2000
`define RCS_WARMUP_S 64'd1800

// report layout
`define RCS_RPT_LAST 5'h1a
`define RCS_RPT_RANGE_MID 5'h07

// range codes
`define RCS_RANGE_CAL 2'h3

// characters
`define RCS_CH_CR 8'h0d
`define RCS_CH_LF 8'h0a
`define RCS_CH_0 8'h30
`define RCS_CH_1 8'h31
`define RCS_CH_C 8'h43
`define RCS_CH_A 8'h41
`define RCS_CH_L 8'h4c
`define RCS_CH_D 8'h44
`define RCS_CH_T 8'h54
`define RCS_CH_DASH 8'h2d

// command words
`define RCS_AUTO_SPAN_CMD 16'h6173
`define RCS_AUTO_ZERO_CMD 16'h617a
`define RCS_STATUS_TOGGLE_CMD 16'h7374
`define RCS_REPROGRAM_CMD 16'h7270
`define RCS_AUTO_RANGE_CMD 16'h7261
`define RCS_MANUAL_RANGE_CMD 16'h726d
`define RCS_CH_FOUR 8'h34

// reset values
`define RCS_RST_STAT_EN 1'b1
`define RCS_RST_WARM 1'b1

`endif

//--- logic/rcs_pkg.sv
// types of the remote calibration and serial status block
// assumes nothing beyond the defines header
package rcs_pkg;

    typedef enum logic [1:0] {
        RCS_IDLE = 2'b00,
        RCS_ZERO = 2'b01,
        RCS_SPAN = 2'b10
    } rcs_cal_e;

    typedef struct packed {
        logic busy;
        logic [8:0] sh;
        logic [3:0] nbit;
        logic [15:0] cyc;
        logic line;
    } rcs_tx_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic act;
        logic [7:0] sh;
        logic [3:0] nbit;
        logic [15:0] cyc;
        logic [7:0] data;
        logic valid;
    } rcs_rx_s;

    typedef struct packed {
        rcs_cal_e state;
        logic zero_s1;
        logic zero_s2;
        logic span_s1;
        logic span_s2;
        logic key_s1;
        logic key_s2;
        logic warm;
        logic [39:0] warm_cnt;
        logic [31:0] rep_cnt;
        logic stat_en;
        logic reprog;
        logic man;
        logic [1:0] sel;
        logic [1:0] range_use;
        logic [3:0] relay;
        logic busy;
        logic v_zero;
        logic v_span;
        logic v_sample;
        logic [15:0] hold;
        logic [23:0] rx_buf;
        logic [2:0] rx_len;
        logic tx_act;
        logic tx_valid;
        logic [4:0] tx_idx;
        logic [7:0] tx_data;
    } rcs_main_s;

endpackage

//--- logic/rcs_uart_if.sv
// byte handshake between the controller and its serial transmitter and receiver
// assumes all parties on ref_clk
`timescale 1ns/10ps
interface rcs_uart_if;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] rx_data;
    logic rx_valid;
    modport ctrl (output tx_data, output tx_valid, input tx_ready,
                  input rx_data, input rx_valid);
    modport tx (input tx_data, input tx_valid, output tx_ready);
    modport rx (output rx_data, output rx_valid);
endinterface

//--- logic/rcs_uart_rx.sv
// serial receiver, 8 data bits, no parity, one stop bit
// assumes serial_rx is asynchronous; idle level high
`timescale 1ns/10ps
module rcs_uart_rx #(
    parameter logic [15:0] BIT_CYC = 16'd16666
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // line
    input wire logic serial_rx,
    // byte side
    rcs_uart_if.rx u
);
    localparam logic [15:0] HALF_CYC = BIT_CYC >> 1;
    localparam rcs_pkg::rcs_rx_s RX_RST = '{s1: 1'b1, s2: 1'b1, default: '0};
    rcs_pkg::rcs_rx_s r;
    rcs_pkg::rcs_rx_s n;

    // start check mid bit, then sample each bit centre
    always_comb begin
        n = r;
        n.s1 = serial_rx;
        n.s2 = r.s1;
        n.valid = 1'b0;
        if (!r.act) begin
            if (!r.s2) begin
                n.act = 1'b1;
                n.cyc = 16'h0000;
                n.nbit = 4'h0;
            end
        end else if (r.cyc == ((r.nbit == 4'h0) ? HALF_CYC : BIT_CYC) - 16'h0001) begin
            n.cyc = 16'h0000;
            if (r.nbit == 4'h0) begin
                if (r.s2) begin
                    n.act = 1'b0;
                end else begin
                    n.nbit = 4'h1;
                end
            end else if (r.nbit == 4'h9) begin
                n.act = 1'b0;
                if (r.s2) begin
                    n.valid = 1'b1;
                    n.data = r.sh;
                end
            end else begin
                n.sh = {r.s2, r.sh[7:1]};
                n.nbit = r.nbit + 4'h1;
            end
        end else begin
            n.cyc = r.cyc + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= RX_RST;
        end else begin
            r <= n;
        end
    end

    assign u.rx_data = r.data;
    assign u.rx_valid = r.valid;
endmodule

//--- logic/rcs_uart_tx.sv
// serial transmitter, 8 data bits, no parity, one stop bit
// assumes tx_valid holds until tx_ready is seen
`timescale 1ns/10ps
module rcs_uart_tx #(
    parameter logic [15:0] BIT_CYC = 16'd16666
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // byte side
    rcs_uart_if.tx u,
    // line
    output logic serial_tx
);
    localparam rcs_pkg::rcs_tx_s TX_RST = '{line: 1'b1, default: '0};
    rcs_pkg::rcs_tx_s r;
    rcs_pkg::rcs_tx_s n;

    // frame shifter
    always_comb begin
        n = r;
        if (!r.busy) begin
            n.line = 1'b1;
            if (u.tx_valid) begin
                n.busy = 1'b1;
                n.line = 1'b0;
                n.sh = {1'b1, u.tx_data};
                n.nbit = 4'h0;
                n.cyc = 16'h0000;
            end
        end else if (r.cyc == BIT_CYC - 16'h0001) begin
            n.cyc = 16'h0000;
            if (r.nbit == 4'h9) begin
                n.busy = 1'b0;
            end else begin
                n.line = r.sh[0];
                n.sh = {1'b1, r.sh[8:1]};
                n.nbit = r.nbit + 4'h1;
            end
        end else begin
            n.cyc = r.cyc + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r <= TX_RST;
        end else begin
            r <= n;
        end
    end

    assign u.tx_ready = !r.busy;
    assign serial_tx = r.line;
endmodule
